// file: dv/sia_host_model.sv
// Purpose: Host that services the interrupt by clearing socket flags
// Assumes: bench raises bits of clear_req while the interrupt is low
// Notes:   Each newly requested socket gets one clear pulse
`timescale 1ns/1ps
module sia_host_model (
    input  wire logic       clk,
    input  wire logic       irq_out_n,
    input  wire logic [7:0] clear_req,
    output logic      [7:0] sock_flag_clear
);
    logic [7:0] served;

    // Clear only sockets not yet served, and only while interrupted
    always @(negedge clk) begin
        if (!irq_out_n && (clear_req & ~served) != 8'h00) begin
            sock_flag_clear <= clear_req & ~served;
            served          <= clear_req;
        end else begin
            sock_flag_clear <= 8'h00;
            if (clear_req == 8'h00)
                served <= 8'h00;
        end
    end
endmodule : sia_host_model

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the socket interrupt aggregator
// Assumes: inputs change on the falling clock edge
// Notes:   Echo unit is shortened so pacing shows in a few cycles
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned ECHO = 4;
    logic        clk, nrst, reg_wr, reg_rd, link_up;
    logic        conflict_event, pppoe_close_event;
    logic        irq_out_n, phy_sleep_ctl, lcp_echo_req;
    logic [15:0] reg_addr, gap;
    logic [7:0]  reg_wdata, reg_rdata, lcp_magic_value, acc, bm;
    logic [7:0]  sock_event, sock_flag_clear, clear_req;
    logic [15:0] ra [12];
    logic [7:0]  rv [12];
    int          fails, checks_done, n;

    sia_irq_agg #(.ECHO_CYC(ECHO)) dut_u (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sock_event(sock_event), .sock_flag_clear(sock_flag_clear),
        .conflict_event(conflict_event),
        .pppoe_close_event(pppoe_close_event), .link_up(link_up),
        .auth_algo_in(8'hC3), .irq_out_n(irq_out_n),
        .phy_sleep_ctl(phy_sleep_ctl), .lcp_magic_value(lcp_magic_value),
        .lcp_echo_req(lcp_echo_req)
    );

    sia_host_model host_u (
        .clk(clk), .irq_out_n(irq_out_n), .clear_req(clear_req),
        .sock_flag_clear(sock_flag_clear)
    );

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tmo;
        fails++;
        $display("CHECK FAILED wait bound expected event seen none");
        conclude();
    endtask : tmo

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    task automatic ev(input logic [7:0] s, input logic c, input logic p);
        @(negedge clk);
        sock_event        = s;
        conflict_event    = c;
        pppoe_close_event = p;
        @(negedge clk);
        sock_event        = 8'h00;
        conflict_event    = 1'b0;
        pppoe_close_event = 1'b0;
    endtask : ev

    // Length of the next high stretch of the interrupt, in cycles
    task automatic high_len(output int len);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (irq_out_n !== 1'b1 && k < 50);
        if (k >= 50)
            tmo();
        len = 0;
        while (irq_out_n === 1'b1 && len < 200) begin
            len++;
            @(negedge clk);
        end
        if (len >= 200)
            tmo();
    endtask : high_len

    task automatic still_high(input int cyc);
        int k;
        k = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (irq_out_n !== 1'b1)
                k++;
        end
        chk("irq idle", 16'(k), 16'h0000);
    endtask : still_high

    // Main sequence
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        link_up = 1'b0;
        sock_event = 8'h00;
        conflict_event = 1'b0;
        pppoe_close_event = 1'b0;
        clear_req = 8'h00;
        fails = 0;
        checks_done = 0;
        ra = '{sia_pkg::A_COMMON_FLAG, sia_pkg::A_SOCK_MASK,
               sia_pkg::A_AUTH_ALGO, sia_pkg::A_VERSION,
               sia_pkg::A_ECHO_IVAL, sia_pkg::A_MAGIC, sia_pkg::A_GAP_HI,
               sia_pkg::A_GAP_LO, sia_pkg::A_SUMMARY, sia_pkg::A_PHY_STATE,
               sia_pkg::A_COMMON_MASK, 16'h0040};
        rv = '{8'h00, 8'h00, 8'hC3, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00,
               8'h00, 8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        chk("idle irq", 16'(irq_out_n), 16'h0001);
        foreach (ra[i]) rd(ra[i], rv[i]);
        $display("test reset values done");

        wr(sia_pkg::A_MAGIC, 8'hA5);
        chk("magic out", {8'h00, lcp_magic_value}, 16'h00A5);
        wr(sia_pkg::A_VERSION, 8'hFF);
        rd(sia_pkg::A_VERSION, 8'h5A);
        wr(sia_pkg::A_AUTH_ALGO, 8'hFF);
        rd(sia_pkg::A_AUTH_ALGO, 8'hC3);
        wr(sia_pkg::A_PHY_STATE, 8'hFF);
        chk("sleep on", 16'(phy_sleep_ctl), 16'h0001);
        rd(sia_pkg::A_PHY_STATE, 8'h08);
        link_up = 1'b1;
        rd(sia_pkg::A_PHY_STATE, 8'h28);
        wr(sia_pkg::A_PHY_STATE, 8'h00);
        chk("sleep off", 16'(phy_sleep_ctl), 16'h0000);
        $display("test registers done");

        // Echo pacing: spacing of two requests, then silence
        wr(sia_pkg::A_ECHO_IVAL, 8'h02);
        n = 0;
        while (lcp_echo_req !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100)
            tmo();
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (lcp_echo_req !== 1'b1 && n < 100);
        chk("echo spacing", 16'(n), 16'(2 * ECHO));
        wr(sia_pkg::A_ECHO_IVAL, 8'h00);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if (lcp_echo_req !== 1'b0)
                n++;
        end
        chk("echo stopped", 16'(n), 16'h0000);
        $display("test echo done");

        // Socket events with a long and a zero re-assertion gap
        for (int g = 0; g < 2; g++) begin
            gap = (g == 0) ? 16'h000F : 16'h0000;
            wr(sia_pkg::A_GAP_HI, gap[15:8]);
            wr(sia_pkg::A_GAP_LO, gap[7:0]);
            rd(sia_pkg::A_GAP_LO, gap[7:0]);
            wr(sia_pkg::A_SOCK_MASK, 8'hFF);
            acc = 8'h00;
            for (int i = 0; i < 8; i++) begin
                ev(8'h01 << i, 1'b0, 1'b0);
                acc = acc | (8'h01 << i);
                chk("irq on event", 16'(irq_out_n), 16'h0000);
                rd(sia_pkg::A_SUMMARY, acc);
            end
            clear_req <= 8'h01;
            high_len(n);
            if (g == 0)
                chk("gap wait", 16'(n), 16'h0010);
            else
                chk("zero gap wait", 16'(n), 16'h0001);
            rd(sia_pkg::A_SUMMARY, 8'hFE);
            clear_req <= 8'hFF;
            repeat (3) @(negedge clk);
            still_high(30);
            rd(sia_pkg::A_SUMMARY, 8'h00);
            clear_req <= 8'h00;
        end
        $display("test socket interrupts done");

        wr(sia_pkg::A_SOCK_MASK, 8'h00);
        ev(8'h10, 1'b0, 1'b0);
        still_high(10);
        rd(sia_pkg::A_SUMMARY, 8'h10);
        wr(sia_pkg::A_SOCK_MASK, 8'h10);
        @(negedge clk);
        chk("irq mask on", 16'(irq_out_n), 16'h0000);
        clear_req <= 8'h10;
        repeat (3) @(negedge clk);
        still_high(10);
        clear_req <= 8'h00;
        $display("test socket mask done");

        // Conflict then PPPoE close, masked off and then enabled
        for (int b = 0; b < 2; b++) begin
            bm = (b == 0) ? 8'h80 : 8'h20;
            wr(sia_pkg::A_COMMON_MASK, 8'h00);
            ev(8'h00, b == 0, b == 1);
            still_high(10);
            rd(sia_pkg::A_COMMON_FLAG, bm);
            wr(sia_pkg::A_COMMON_MASK, bm);
            @(negedge clk);
            chk("common irq", 16'(irq_out_n), 16'h0000);
            wr(sia_pkg::A_COMMON_FLAG, bm);
            rd(sia_pkg::A_COMMON_FLAG, 8'h00);
            chk("irq released", 16'(irq_out_n), 16'h0001);
        end
        $display("test common interrupts done");
        conclude();
    end
endmodule : tb_top

// file: rtl/sia_echo_timer.sv
// Purpose: Paces LCP echo requests in units of the echo time base
// Assumes: interval 0 stops the requests
// Notes:   A change of interval restarts the spacing from zero
`timescale 1ns/1ps
module sia_echo_timer #(
    parameter int unsigned UNIT_CYC = sia_pkg::ECHO_UNIT_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] interval,
    output logic            echo_req
);
    localparam int unsigned PW = $clog2(UNIT_CYC + 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [7:0]    units;
        logic [7:0]    last_iv;
        logic          req;
    } sia_echo_st_t;

    sia_echo_st_t s;
    sia_echo_st_t next_s;

    // Time base divider, then count whole units up to the interval
    always_comb begin
        next_s         = s;
        next_s.req     = 1'b0;
        next_s.last_iv = interval;
        if (interval != s.last_iv || interval == 8'h00) begin
            next_s.pre   = '0;
            next_s.units = 8'h00;
        end else if (s.pre == PW'(UNIT_CYC - 1)) begin
            next_s.pre = '0;
            if (s.units == interval - 8'h01) begin
                next_s.units = 8'h00;
                next_s.req   = 1'b1;
            end else begin
                next_s.units = s.units + 8'h01;
            end
        end else begin
            next_s.pre = s.pre + PW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign echo_req = s.req;
endmodule : sia_echo_timer

// file: rtl/sia_gap_timer.sv
// Purpose: Down counter that times the interrupt re-assertion gap
// Assumes: load and count on the same clock as the aggregator
// Notes:   done is high while the count stands at zero
`timescale 1ns/1ps
module sia_gap_timer #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } sia_gap_st_t;

    sia_gap_st_t s;
    sia_gap_st_t next_s;

    // Load wins over the running count
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.cnt = load_val;
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = (s.cnt == '0);
endmodule : sia_gap_timer

// file: rtl/sia_irq_agg.sv
// Purpose: Socket interrupt aggregation and common status registers
// Assumes: Host port delivers decoded one-cycle read and write strobes
// Notes:   Operation
//Operation
//- Echo interval paces LCP echo requests, 25ms units
//- Magic register feeds LCP magic option
//- Read-only PPPoE authentication algorithm register
//- 16-bit re-assertion gap, counted in clocks
//- Clear with others pending: release, wait gap+1
//- Zero gap: re-assert one clock after clear
//- Socket event sets its summary bit
//- Socket flag clear clears its summary bit
//- Masked summary bit drives interrupt low
//- Interrupt stays low until a set flag is cleared
//- PHY status bit 5 shows link up
//- PHY status bit 3 is power-down control
//- Common mask gates conflict and PPPoE close
//- Read-only fixed chip version register
//- Common flags set by events, write-one clears
//- Per-socket mask register at 0x0016
`timescale 1ns/1ps
module sia_irq_agg #(
    parameter int unsigned NSOCK        = 8,
    parameter int unsigned ECHO_CYC     = sia_pkg::ECHO_UNIT_CYC,
    // Arbitrary neutral identification value
    parameter logic [7:0]  CHIP_VERSION = 8'h5A
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [15:0]      reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    input  wire logic [NSOCK-1:0] sock_event,
    input  wire logic [NSOCK-1:0] sock_flag_clear,
    input  wire logic             conflict_event,
    input  wire logic             pppoe_close_event,
    input  wire logic             link_up,
    input  wire logic [7:0]       auth_algo_in,
    output logic                  irq_out_n,
    output logic                  phy_sleep_ctl,
    output logic      [7:0]       lcp_magic_value,
    output logic                  lcp_echo_req
);
    typedef struct packed {
        sia_pkg::sia_irq_state_t state;
        logic                    irq_n;
        logic [NSOCK-1:0]        summary;
        logic [NSOCK-1:0]        sock_mask;
        logic [7:0]              common;
        logic [7:0]              common_mask;
        logic [15:0]             gap;
        logic [7:0]              echo_ival;
        logic [7:0]              magic;
        logic [7:0]              auth;
        logic                    link;
        logic                    sleep;
        logic [7:0]              rdata;
    } sia_agg_st_t;

    sia_agg_st_t s;
    sia_agg_st_t next_s;
    logic        gap_done;
    logic        gap_load;
    logic        npend;
    logic        clear_evt;
    logic [7:0]  common_set;
    logic [7:0]  common_w1c;

    // Any enabled source pending
    function automatic logic sia_pending(
        input logic [NSOCK-1:0] sum,
        input logic [NSOCK-1:0] smask,
        input logic [7:0]       com,
        input logic [7:0]       cmask
    );
        sia_pending = (|(sum & smask)) |
                      (|(com & cmask & sia_pkg::COMMON_USED));
    endfunction : sia_pending

    // Register read value for one address
    function automatic logic [7:0] sia_read(
        input logic [15:0] a,
        input sia_agg_st_t r
    );
        logic [7:0] v;
        v = 8'h00;
        if (a == sia_pkg::A_COMMON_FLAG) begin
            v = r.common;
        end else if (a == sia_pkg::A_SOCK_MASK) begin
            v = 8'(r.sock_mask);
        end else if (a == sia_pkg::A_AUTH_ALGO) begin
            v = r.auth;
        end else if (a == sia_pkg::A_VERSION) begin
            v = CHIP_VERSION;
        end else if (a == sia_pkg::A_ECHO_IVAL) begin
            v = r.echo_ival;
        end else if (a == sia_pkg::A_MAGIC) begin
            v = r.magic;
        end else if (a == sia_pkg::A_GAP_HI) begin
            v = r.gap[15:8];
        end else if (a == sia_pkg::A_GAP_LO) begin
            v = r.gap[7:0];
        end else if (a == sia_pkg::A_SUMMARY) begin
            v = 8'(r.summary);
        end else if (a == sia_pkg::A_PHY_STATE) begin
            v[sia_pkg::B_LINK]  = r.link;
            v[sia_pkg::B_SLEEP] = r.sleep;
        end else if (a == sia_pkg::A_COMMON_MASK) begin
            v = r.common_mask;
        end
        sia_read = v;
    endfunction : sia_read

    // Event inputs placed at their common flag positions
    always_comb begin
        common_set                         = 8'h00;
        common_set[sia_pkg::B_CONFLICT]    = conflict_event;
        common_set[sia_pkg::B_PPPOE_CLOSE] = pppoe_close_event;
        common_w1c = 8'h00;
        if (reg_wr && reg_addr == sia_pkg::A_COMMON_FLAG) begin
            common_w1c = reg_wdata & sia_pkg::COMMON_USED;
        end
    end

    // Registers, flags and interrupt state
    always_comb begin
        next_s       = s;
        gap_load     = 1'b0;
        // Set wins over clear on the same cycle
        next_s.summary = (s.summary & ~sock_flag_clear)
                       | sock_event;
        next_s.common  = (s.common & ~common_w1c)
                       | common_set;
        next_s.auth    = auth_algo_in;
        next_s.link    = link_up;
        if (reg_wr) begin
            if (reg_addr == sia_pkg::A_SOCK_MASK) begin
                next_s.sock_mask = NSOCK'(reg_wdata);
            end else if (reg_addr == sia_pkg::A_ECHO_IVAL) begin
                next_s.echo_ival = reg_wdata;
            end else if (reg_addr == sia_pkg::A_MAGIC) begin
                next_s.magic = reg_wdata;
            end else if (reg_addr == sia_pkg::A_GAP_HI) begin
                next_s.gap[15:8] = reg_wdata;
            end else if (reg_addr == sia_pkg::A_GAP_LO) begin
                next_s.gap[7:0] = reg_wdata;
            end else if (reg_addr == sia_pkg::A_PHY_STATE) begin
                next_s.sleep = reg_wdata[sia_pkg::B_SLEEP];
            end else if (reg_addr == sia_pkg::A_COMMON_MASK) begin
                next_s.common_mask = reg_wdata;
            end
        end
        if (reg_rd) begin
            next_s.rdata = sia_read(reg_addr, s);
        end
        npend = sia_pending(next_s.summary, next_s.sock_mask,
                            next_s.common, next_s.common_mask);
        // A clear that actually drops a set flag
        clear_evt = (|(sock_flag_clear & s.summary & ~sock_event))
                  | (|(common_w1c & s.common & ~common_set));
        case (s.state)
            sia_pkg::SIA_IDLE: begin
                if (npend) begin
                    next_s.state = sia_pkg::SIA_ASSERT;
                end
            end
            sia_pkg::SIA_ASSERT: begin
                if (!npend) begin
                    next_s.state = sia_pkg::SIA_IDLE;
                end else if (clear_evt) begin
                    next_s.state = sia_pkg::SIA_GAP;
                    gap_load     = 1'b1;
                end
            end
            sia_pkg::SIA_GAP: begin
                if (gap_done) begin
                    next_s.state = npend ? sia_pkg::SIA_ASSERT
                                         : sia_pkg::SIA_IDLE;
                end
            end
            default: begin
                next_s.state = sia_pkg::SIA_IDLE;
            end
        endcase
        next_s.irq_n = (next_s.state != sia_pkg::SIA_ASSERT);
    end

    // State register, loaded with reset values
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s             <= '0;
            s.state       <= sia_pkg::SIA_IDLE;
            s.irq_n       <= 1'b1;
            s.common      <= sia_pkg::R_BYTE;
            s.common_mask <= sia_pkg::R_BYTE;
            s.gap         <= sia_pkg::R_GAP;
        end else begin
            s <= next_s;
        end
    end

    // Gap count of gap+1 clocks with the output released
    sia_gap_timer #(
        .W        (16)
    ) u_gap (
        .clk      (clk),
        .nrst     (nrst),
        .load     (gap_load),
        .load_val (s.gap),
        .done     (gap_done)
    );

    // LCP echo request pacing
    sia_echo_timer #(
        .UNIT_CYC (ECHO_CYC)
    ) u_echo (
        .clk      (clk),
        .nrst     (nrst),
        .interval (s.echo_ival),
        .echo_req (lcp_echo_req)
    );

    // Outputs straight from flip-flops
    assign irq_out_n       = s.irq_n;
    assign reg_rdata       = s.rdata;
    assign phy_sleep_ctl   = s.sleep;
    assign lcp_magic_value = s.magic;

    // Helper: length of the released stretch in the gap state
    logic [16:0] g_cnt;
    always_ff @(posedge clk) begin
        if (!nrst || s.state != sia_pkg::SIA_GAP) begin
            g_cnt <= 17'h0_0000;
        end else begin
            g_cnt <= g_cnt + 17'h0_0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_sum_set;
        sock_event[0] |=> s.summary[0];
    endproperty
    a_sum_set: assert property (p_sum_set)
        else $error("summary bit not set by socket event");

    property p_sum_clr;
        sock_flag_clear[1] && !sock_event[1] |=> !s.summary[1];
    endproperty
    a_sum_clr: assert property (p_sum_clr)
        else $error("summary bit not cleared by flag clear");

    property p_irq_low;
        s.state == sia_pkg::SIA_IDLE && sock_event[0] && s.sock_mask[0] &&
        !reg_wr |=> !irq_out_n;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("masked summary did not pull interrupt low");

    property p_irq_idle;
        !sia_pending(s.summary, s.sock_mask, s.common, s.common_mask)
        |-> irq_out_n;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("interrupt low with nothing pending");

    property p_gap_len;
        s.state == sia_pkg::SIA_ASSERT &&
        $past(s.state) == sia_pkg::SIA_GAP
        |-> g_cnt == {1'b0, s.gap} + 17'h0_0001;
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("re-assertion gap length wrong");

    property p_gap_zero;
        s.state == sia_pkg::SIA_ASSERT && clear_evt && npend &&
        s.gap == 16'h0000 |=> irq_out_n ##1 !irq_out_n;
    endproperty
    a_gap_zero: assert property (p_gap_zero)
        else $error("zero gap did not re-assert after one clock");

    property p_w1c;
        reg_wr && reg_addr == sia_pkg::A_COMMON_FLAG &&
        reg_wdata[7] && !conflict_event |=> !s.common[7];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("conflict flag not cleared by write of one");

    property p_common_gate;
        s.state == sia_pkg::SIA_IDLE && s.summary == '0 &&
        s.common_mask == 8'h00 && !reg_wr && sock_event == '0
        |=> irq_out_n;
    endproperty
    a_common_gate: assert property (p_common_gate)
        else $error("masked common flag reached interrupt");

    property p_sleep;
        reg_wr && reg_addr == sia_pkg::A_PHY_STATE
        |=> phy_sleep_ctl == $past(reg_wdata[3]);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("power-down control not written");

    property p_version;
        reg_rd && reg_addr == sia_pkg::A_VERSION
        |=> reg_rdata == CHIP_VERSION;
    endproperty
    a_version: assert property (p_version)
        else $error("version register value wrong");

    property p_echo;
        lcp_echo_req |-> $past(s.echo_ival) != 8'h00;
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo request with zero interval");

    property p_magic;
        reg_wr && reg_addr == sia_pkg::A_MAGIC
        |=> lcp_magic_value == $past(reg_wdata);
    endproperty
    a_magic: assert property (p_magic)
        else $error("magic value not written");

    property p_link;
        reg_rd && reg_addr == sia_pkg::A_PHY_STATE
        |=> reg_rdata[sia_pkg::B_LINK] == $past(s.link);
    endproperty
    a_link: assert property (p_link)
        else $error("link bit not reported");

    property p_mask_off;
        s.state == sia_pkg::SIA_IDLE && !reg_wr && sock_event == 8'h10 &&
        !s.sock_mask[4] && !conflict_event && !pppoe_close_event
        |=> irq_out_n;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("masked socket reached interrupt");

    property p_reset;
        disable iff (1'b0)
        !nrst |=> irq_out_n && reg_rdata == 8'h00 && !phy_sleep_ctl;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not at reset values");
endmodule : sia_irq_agg

// file: rtl/sia_pkg.sv
// Purpose: Shared constants for the socket interrupt aggregator
// Assumes: 8-bit register data, 16-bit register addresses
// Notes:   Register offsets are byte addresses on the host port
package sia_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned ECHO_UNIT_MS  = 25;
    localparam int unsigned ECHO_UNIT_CYC = ECHO_UNIT_MS * (CLK_HZ / 1000);

    // Register offsets
    localparam logic [15:0] A_COMMON_FLAG = 16'h0015;
    localparam logic [15:0] A_SOCK_MASK   = 16'h0016;
    localparam logic [15:0] A_AUTH_ALGO   = 16'h001E;
    localparam logic [15:0] A_VERSION     = 16'h001F;
    localparam logic [15:0] A_ECHO_IVAL   = 16'h0028;
    localparam logic [15:0] A_MAGIC       = 16'h0029;
    localparam logic [15:0] A_GAP_HI      = 16'h0030;
    localparam logic [15:0] A_GAP_LO      = 16'h0031;
    localparam logic [15:0] A_SUMMARY     = 16'h0034;
    localparam logic [15:0] A_PHY_STATE   = 16'h0035;
    localparam logic [15:0] A_COMMON_MASK = 16'h0036;

    // Field positions
    localparam int unsigned B_CONFLICT    = 7;
    localparam int unsigned B_PPPOE_CLOSE = 5;
    localparam int unsigned B_LINK        = 5;
    localparam int unsigned B_SLEEP       = 3;
    localparam logic [7:0]  COMMON_USED   = 8'hA0;

    // Values after reset
    localparam logic [7:0]  R_BYTE        = 8'h00;
    localparam logic [15:0] R_GAP         = 16'h0000;

    // Interrupt output states
    typedef enum logic [1:0] {
        SIA_IDLE   = 2'b00,
        SIA_ASSERT = 2'b01,
        SIA_GAP    = 2'b10
    } sia_irq_state_t;
endpackage : sia_pkg
